/* File: verilog/split_timer_pkg.sv */
// Constants shared by the split auto-reload timer and its tick generator
package split_timer_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CTRL_OFFSET        = 8'h91;
    localparam logic [7:0] RELOAD_LOW_OFFSET  = 8'h92;
    localparam logic [7:0] RELOAD_HIGH_OFFSET = 8'h93;
    localparam logic [7:0] COUNT_LOW_OFFSET   = 8'h94;
    localparam logic [7:0] COUNT_HIGH_OFFSET  = 8'h95;
    localparam logic [7:0] CLK_CTRL_OFFSET    = 8'h96;
    localparam logic [7:0] INT_EN_OFFSET      = 8'h97;
    localparam logic [7:0] IRQ_STAT_OFFSET    = 8'h98;
    localparam logic [7:0] IRQ_MASK_OFFSET    = 8'h99;

    // Control register fields
    localparam int HIGH_FLAG_BIT   = 7;
    localparam int LOW_FLAG_BIT    = 6;
    localparam int LOW_IRQ_EN_BIT  = 5;
    localparam int SPLIT_BIT       = 3;
    localparam int RUN_BIT         = 2;
    localparam int EXT_CLK_SEL_BIT = 0;

    // Clock control register fields
    localparam int HIGH_CLK_SEL_BIT = 1;
    localparam int LOW_CLK_SEL_BIT  = 0;

    // Interrupt enable register field
    localparam int TIMER_INT_EN_BIT = 0;

    // Interrupt status and mask fields
    localparam int IRQ_HIGH_BIT = 1;
    localparam int IRQ_LOW_BIT  = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [1:0] CLK_CTRL_RESET = 2'h0;
    localparam logic       INT_EN_RESET   = 1'b0;
    localparam logic [1:0] IRQ_STAT_RESET = 2'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // Byte and word limits
    localparam logic [7:0]  BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [7:0]  BYTE_ONE = 8'h01;

    // Prescaler ratios
    localparam logic [3:0] SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    // Operating mode
    typedef enum logic {MODE_WIDE, MODE_SPLIT} timer_mode_t;

endpackage

/* File: verilog/count_tick_gen.sv */
// Count clock enables: system clock by 12, external oscillator by 8
`timescale 1ns/10ps
module count_tick_gen
(
    input  wire logic ref_clk,      // System clock
    input  wire logic reset,        // Async reset, active high
    input  wire logic extClk,       // External oscillator pin
    output logic      sysDiv12Tick, // One-cycle enable, rate /12
    output logic      extDiv8Tick   // One-cycle enable, ext rate /8
);

    logic [3:0] sysDiv_r;
    logic       extSync1_r;
    logic       extSync2_r;
    logic       extPrev_r;
    logic [2:0] extDiv_r;
    logic       extRise;

    // Free running prescaler for the divide by 12 rate
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sysDiv_r     <= 4'h0;
            sysDiv12Tick <= 1'b0;
        end
        else
        begin
            sysDiv12Tick <= (sysDiv_r == split_timer_pkg::SYS_DIV_LAST);
            if (sysDiv_r == split_timer_pkg::SYS_DIV_LAST)
                sysDiv_r <= 4'h0;
            else
                sysDiv_r <= sysDiv_r + 4'h1;
        end
    end

    // Two flops before any logic sees the pin
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            extSync1_r <= 1'b0;
            extSync2_r <= 1'b0;
            extPrev_r  <= 1'b0;
        end
        else
        begin
            extSync1_r <= extClk;
            extSync2_r <= extSync1_r;
            extPrev_r  <= extSync2_r;
        end
    end

    // Edge taken from the second and third stage only
    assign extRise = extSync2_r & ~extPrev_r;

    // Eight synchronized rising edges give one tick
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            extDiv_r    <= 3'h0;
            extDiv8Tick <= 1'b0;
        end
        else
        begin
            extDiv8Tick <= extRise &&
                           (extDiv_r == split_timer_pkg::EXT_DIV_LAST);
            if (extRise)
                extDiv_r <= extDiv_r + 3'h1;
        end
    end

endmodule

/* File: verilog/split_autoreload_timer.sv */
// Split 16-bit or dual 8-bit auto-reload timer with register port
`timescale 1ns/10ps
module split_autoreload_timer
(
    input  wire logic       ref_clk,   // System clock, 20 MHz
    input  wire logic       reset,     // Async reset, active high
    input  wire logic [7:0] regAddr,   // Register address
    input  wire logic [7:0] regWrData, // Register write data
    input  wire logic       regWrite,  // Write strobe
    input  wire logic       regRead,   // Read strobe
    output logic      [7:0] regRdData, // Read data, cycle after strobe
    input  wire logic       extOscClk, // External oscillator pin
    output logic            timerIrq   // Interrupt request level
);

    // Stored state
    logic       highFlag_r;
    logic       lowFlag_r;
    logic       lowIrqEn_r;
    logic       splitSel_r;
    logic       runCtl_r;
    logic       extClkSel_r;
    logic [7:0] reloadLow_r;
    logic [7:0] reloadHigh_r;
    logic [7:0] countLow_r;
    logic [7:0] countHigh_r;
    logic [1:0] clkCtl_r;
    logic       timerIntEn_r;
    logic [1:0] irqStat_r;
    logic [1:0] irqMask_r;

    // Next values and events
    logic [7:0]  countLow_nxt;
    logic [7:0]  countHigh_nxt;
    logic [15:0] wideSum;
    logic        highOvf;
    logic        lowOvf;
    logic        sysDiv12Tick;
    logic        extDiv8Tick;
    logic        slowTick;
    logic        lowTick;
    logic        highTick;
    logic        irqPending;
    split_timer_pkg::timer_mode_t mode;

    // Write decode
    logic wrCtrl;
    logic wrReloadLow;
    logic wrReloadHigh;
    logic wrCountLow;
    logic wrCountHigh;
    logic wrClkCtl;
    logic wrIntEn;
    logic wrIrqStat;
    logic wrIrqMask;

    assign wrCtrl       = regWrite &&
                          (regAddr == split_timer_pkg::CTRL_OFFSET);
    assign wrReloadLow  = regWrite &&
                          (regAddr == split_timer_pkg::RELOAD_LOW_OFFSET);
    assign wrReloadHigh = regWrite &&
                          (regAddr == split_timer_pkg::RELOAD_HIGH_OFFSET);
    assign wrCountLow   = regWrite &&
                          (regAddr == split_timer_pkg::COUNT_LOW_OFFSET);
    assign wrCountHigh  = regWrite &&
                          (regAddr == split_timer_pkg::COUNT_HIGH_OFFSET);
    assign wrClkCtl     = regWrite &&
                          (regAddr == split_timer_pkg::CLK_CTRL_OFFSET);
    assign wrIntEn      = regWrite &&
                          (regAddr == split_timer_pkg::INT_EN_OFFSET);
    assign wrIrqStat    = regWrite &&
                          (regAddr == split_timer_pkg::IRQ_STAT_OFFSET);
    assign wrIrqMask    = regWrite &&
                          (regAddr == split_timer_pkg::IRQ_MASK_OFFSET);

    // Prescalers and external clock synchronizer
    count_tick_gen u_ticks
    (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .extClk       (extOscClk),
        .sysDiv12Tick (sysDiv12Tick),
        .extDiv8Tick  (extDiv8Tick)
    );

    // Slow clock shared by both bytes, per external select
    assign slowTick = extClkSel_r ? extDiv8Tick : sysDiv12Tick;

    // Per byte choice of system clock or the slow clock
    assign lowTick  = clkCtl_r[split_timer_pkg::LOW_CLK_SEL_BIT] ?
                      1'b1 : slowTick;
    assign highTick = clkCtl_r[split_timer_pkg::HIGH_CLK_SEL_BIT] ?
                      1'b1 : slowTick;

    // Mode from the split select bit
    assign mode = splitSel_r ? split_timer_pkg::MODE_SPLIT
                             : split_timer_pkg::MODE_WIDE;

    assign wideSum = {countHigh_r, countLow_r} + split_timer_pkg::WORD_ONE;

    // Counter step; wide mode follows the low byte clock
    always_comb
    begin
        countLow_nxt  = countLow_r;
        countHigh_nxt = countHigh_r;
        highOvf       = 1'b0;
        lowOvf        = 1'b0;
        unique case (mode)
            split_timer_pkg::MODE_WIDE:
            begin
                if (runCtl_r && lowTick)
                begin
                    if ({countHigh_r, countLow_r} ==
                        split_timer_pkg::WORD_MAX)
                    begin
                        countLow_nxt  = reloadLow_r;
                        countHigh_nxt = reloadHigh_r;
                        highOvf       = 1'b1;
                        lowOvf        = 1'b1;
                    end
                    else
                    begin
                        countLow_nxt  = wideSum[7:0];
                        countHigh_nxt = wideSum[15:8];
                        lowOvf = (countLow_r == split_timer_pkg::BYTE_MAX);
                    end
                end
            end
            split_timer_pkg::MODE_SPLIT:
            begin
                // Low byte ignores run control in this mode
                if (lowTick)
                begin
                    if (countLow_r == split_timer_pkg::BYTE_MAX)
                    begin
                        countLow_nxt = reloadLow_r;
                        lowOvf       = 1'b1;
                    end
                    else
                        countLow_nxt = countLow_r + split_timer_pkg::BYTE_ONE;
                end
                if (runCtl_r && highTick)
                begin
                    if (countHigh_r == split_timer_pkg::BYTE_MAX)
                    begin
                        countHigh_nxt = reloadHigh_r;
                        highOvf       = 1'b1;
                    end
                    else
                        countHigh_nxt = countHigh_r +
                                        split_timer_pkg::BYTE_ONE;
                end
            end
        endcase
    end

    // Count bytes; a software write to a byte wins over counting
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            countLow_r  <= split_timer_pkg::BYTE_RESET;
            countHigh_r <= split_timer_pkg::BYTE_RESET;
        end
        else
        begin
            if (wrCountLow)
                countLow_r <= regWrData;
            else
                countLow_r <= countLow_nxt;
            if (wrCountHigh)
                countHigh_r <= regWrData;
            else
                countHigh_r <= countHigh_nxt;
        end
    end

    // Reload registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            reloadLow_r  <= split_timer_pkg::BYTE_RESET;
            reloadHigh_r <= split_timer_pkg::BYTE_RESET;
        end
        else
        begin
            if (wrReloadLow)
                reloadLow_r <= regWrData;
            if (wrReloadHigh)
                reloadHigh_r <= regWrData;
        end
    end

    // Control bits other than the flags
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            lowIrqEn_r  <= split_timer_pkg::CTRL_RESET[5];
            splitSel_r  <= split_timer_pkg::CTRL_RESET[3];
            runCtl_r    <= split_timer_pkg::CTRL_RESET[2];
            extClkSel_r <= split_timer_pkg::CTRL_RESET[0];
        end
        else if (wrCtrl)
        begin
            lowIrqEn_r  <= regWrData[split_timer_pkg::LOW_IRQ_EN_BIT];
            splitSel_r  <= regWrData[split_timer_pkg::SPLIT_BIT];
            runCtl_r    <= regWrData[split_timer_pkg::RUN_BIT];
            extClkSel_r <= regWrData[split_timer_pkg::EXT_CLK_SEL_BIT];
        end
    end

    // Overflow flags: only software writes clear, a new overflow wins
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            highFlag_r <= split_timer_pkg::CTRL_RESET[7];
            lowFlag_r  <= split_timer_pkg::CTRL_RESET[6];
        end
        else
        begin
            if (highOvf)
                highFlag_r <= 1'b1;
            else if (wrCtrl)
                highFlag_r <= regWrData[split_timer_pkg::HIGH_FLAG_BIT];
            if (lowOvf)
                lowFlag_r <= 1'b1;
            else if (wrCtrl)
                lowFlag_r <= regWrData[split_timer_pkg::LOW_FLAG_BIT];
        end
    end

    // Clock select and interrupt enable registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            clkCtl_r     <= split_timer_pkg::CLK_CTRL_RESET;
            timerIntEn_r <= split_timer_pkg::INT_EN_RESET;
        end
        else
        begin
            if (wrClkCtl)
                clkCtl_r <= regWrData[1:0];
            if (wrIntEn)
                timerIntEn_r <= regWrData[split_timer_pkg::TIMER_INT_EN_BIT];
        end
    end

    // Sticky event status, write one to clear, set beats clear
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            irqStat_r <= split_timer_pkg::IRQ_STAT_RESET;
        else
        begin
            irqStat_r[split_timer_pkg::IRQ_HIGH_BIT] <= highOvf ||
                (irqStat_r[split_timer_pkg::IRQ_HIGH_BIT] &&
                 !(wrIrqStat && regWrData[split_timer_pkg::IRQ_HIGH_BIT]));
            irqStat_r[split_timer_pkg::IRQ_LOW_BIT] <= lowOvf ||
                (irqStat_r[split_timer_pkg::IRQ_LOW_BIT] &&
                 !(wrIrqStat && regWrData[split_timer_pkg::IRQ_LOW_BIT]));
        end
    end

    // Mask opens both sources after reset
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            irqMask_r <= split_timer_pkg::IRQ_MASK_RESET;
        else if (wrIrqMask)
            irqMask_r <= regWrData[1:0];
    end

    // Low source needs its own enable in either mode
    assign irqPending =
        (irqStat_r[split_timer_pkg::IRQ_HIGH_BIT] &&
         irqMask_r[split_timer_pkg::IRQ_HIGH_BIT]) ||
        (irqStat_r[split_timer_pkg::IRQ_LOW_BIT] &&
         irqMask_r[split_timer_pkg::IRQ_LOW_BIT] &&
         lowIrqEn_r);

    // Registered request level, one cycle behind the status
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            timerIrq <= 1'b0;
        else
            timerIrq <= timerIntEn_r && irqPending;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            regRdData <= split_timer_pkg::UNMAPPED_READ;
        else if (!regRead)
            regRdData <= split_timer_pkg::UNMAPPED_READ;
        else
        begin
            unique case (regAddr)
                split_timer_pkg::CTRL_OFFSET:
                    regRdData <= {highFlag_r, lowFlag_r, lowIrqEn_r, 1'b0,
                                  splitSel_r, runCtl_r, 1'b0,
                                  extClkSel_r};
                split_timer_pkg::RELOAD_LOW_OFFSET:
                    regRdData <= reloadLow_r;
                split_timer_pkg::RELOAD_HIGH_OFFSET:
                    regRdData <= reloadHigh_r;
                split_timer_pkg::COUNT_LOW_OFFSET:
                    regRdData <= countLow_r;
                split_timer_pkg::COUNT_HIGH_OFFSET:
                    regRdData <= countHigh_r;
                split_timer_pkg::CLK_CTRL_OFFSET:
                    regRdData <= {6'h00, clkCtl_r};
                split_timer_pkg::INT_EN_OFFSET:
                    regRdData <= {7'h00, timerIntEn_r};
                split_timer_pkg::IRQ_STAT_OFFSET:
                    regRdData <= {6'h00, irqStat_r};
                split_timer_pkg::IRQ_MASK_OFFSET:
                    regRdData <= {6'h00, irqMask_r};
                default:
                    regRdData <= split_timer_pkg::UNMAPPED_READ;
            endcase
        end
    end

endmodule

/* File: tb/split_timer_monitor.sv */
// Port-level assertions for the split auto-reload timer
`timescale 1ns/10ps
module split_timer_monitor
(
    input wire logic       ref_clk,   // System clock
    input wire logic       reset,     // Async reset, active high
    input wire logic [7:0] regAddr,   // Register address
    input wire logic [7:0] regWrData, // Write data
    input wire logic       regWrite,  // Write strobe
    input wire logic       regRead,   // Read strobe
    input wire logic [7:0] regRdData, // Read data
    input wire logic       extOscClk, // External oscillator
    input wire logic       timerIrq   // Interrupt request
);
    logic       intEn_r;    // Shadow of timer interrupt enable
    logic [1:0] mask_r;     // Shadow of interrupt mask
    logic       ctrlRd_r;   // Control read answered now
    logic [1:0] seenFlag_r; // Flags already seen set

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Shadows follow software writes only
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            intEn_r <= split_timer_pkg::INT_EN_RESET;
            mask_r  <= split_timer_pkg::IRQ_MASK_RESET;
        end
        else if (regWrite && regAddr == split_timer_pkg::INT_EN_OFFSET)
            intEn_r <= regWrData[0];
        else if (regWrite && regAddr == split_timer_pkg::IRQ_MASK_OFFSET)
            mask_r <= regWrData[1:0];
    end

    // Only a control write may drop a flag once seen
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrlRd_r   <= 1'b0;
            seenFlag_r <= 2'h0;
        end
        else
        begin
            ctrlRd_r <= regRead && regAddr == split_timer_pkg::CTRL_OFFSET;
            if (regWrite && regAddr == split_timer_pkg::CTRL_OFFSET)
                seenFlag_r <= 2'h0;
            else if (ctrlRd_r)
                seenFlag_r <= seenFlag_r | regRdData[7:6];
        end
    end

    sequence wrThenRead(logic [7:0] a, logic [7:0] b);
        regWrite && (regAddr == a || regAddr == b) ##1 !regWrite
            ##1 regRead && regAddr == $past(regAddr, 2);
    endsequence

    a_read_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_unmapped_read: assert property (regRead && (regAddr < 8'h91 ||
        regAddr > 8'h99) |=> regRdData == split_timer_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_ctrl_reserved_bits: assert property (regRead &&
        regAddr == split_timer_pkg::CTRL_OFFSET
        |=> !regRdData[4] && !regRdData[1])
        else $error("reserved control bits read as one");
    a_reload_read_back: assert property (wrThenRead(8'h92, 8'h93)
        |=> regRdData == $past(regWrData, 3))
        else $error("reload byte not read back");
    a_ctrl_read_back: assert property (wrThenRead(8'h91, 8'h91)
        |=> (regRdData & 8'h2d) == ($past(regWrData, 3) & 8'h2d))
        else $error("control bits not read back");
    a_flags_stay_set: assert property (ctrlRd_r
        |-> (regRdData[7:6] & seenFlag_r) == seenFlag_r)
        else $error("overflow flag cleared without software");
    a_irq_needs_enable: assert property (!intEn_r && !(regWrite &&
        regAddr == split_timer_pkg::INT_EN_OFFSET) |=> !timerIrq)
        else $error("interrupt raised while disabled");
    a_irq_masked_off: assert property (mask_r == 2'h0 && !(regWrite &&
        regAddr == split_timer_pkg::IRQ_MASK_OFFSET) |=> !timerIrq)
        else $error("interrupt raised while masked");
endmodule

bind split_autoreload_timer split_timer_monitor mon_u
(
    .ref_clk   (ref_clk),
    .reset     (reset),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWrite  (regWrite),
    .regRead   (regRead),
    .regRdData (regRdData),
    .extOscClk (extOscClk),
    .timerIrq  (timerIrq)
);

/* File: tb/split_autoreload_timer_tb.sv */
// Self-checking bench for the split auto-reload timer
`timescale 1ns/10ps
module split_autoreload_timer_tb;
    localparam logic [7:0] A_CTRL = 8'h91;
    localparam logic [7:0] A_RLL  = 8'h92;
    localparam logic [7:0] A_RLH  = 8'h93;
    localparam logic [7:0] A_CL   = 8'h94;
    localparam logic [7:0] A_CH   = 8'h95;
    localparam logic [7:0] A_CLK  = 8'h96;
    localparam logic [7:0] A_IEN  = 8'h97;
    localparam logic [7:0] A_STAT = 8'h98;
    localparam logic [7:0] A_MASK = 8'h99;
    logic       ref_clk;   // System clock
    logic       reset;     // Async reset
    logic [7:0] regAddr;   // Register address
    logic [7:0] regWrData; // Write data
    logic       regWrite;  // Write strobe
    logic       regRead;   // Read strobe
    logic [7:0] regRdData; // Read data
    logic       extOscClk; // External oscillator
    logic       timerIrq;  // Interrupt request
    logic       extOn;     // Lets the oscillator run
    logic [7:0] rdVal;     // Last read value
    logic [7:0] rl;        // Random reload low
    logic [7:0] rh;        // Random reload high
    logic [7:0] cv;        // Random count value
    integer     seed;
    int         n_mismatch;
    int         num_checks;

    split_autoreload_timer dut_u
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrite  (regWrite),
        .regRead   (regRead),
        .regRdData (regRdData),
        .extOscClk (extOscClk),
        .timerIrq  (timerIrq)
    );

    // 20 MHz system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Oscillator stands still unless a scenario wants it
    always @(posedge ref_clk)
        if (reset)
            extOscClk <= 1'b0;
        else if (extOn)
            extOscClk <= ~extOscClk;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge ref_clk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdVal = regRdData;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkIn(input logic [7:0] lo, input logic [7:0] hi);
        num_checks++;
        if ($isunknown(rdVal) || rdVal < lo || rdVal > hi)
        begin
            n_mismatch++;
            $display("[ERR] %0t count %h outside %h..%h",
                     $time, rdVal, lo, hi);
        end
    endtask

    // Step off the edge so the level launched there has settled
    task automatic chkIrq(input logic exp);
        #1;
        num_checks++;
        if (timerIrq !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t irq %b expected %b", $time, timerIrq, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk8(rdVal, e);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end

    // Main sequence
    initial
    begin
        seed = 32'hc8d1;
        n_mismatch = 0;
        num_checks = 0;
        reset = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        extOn = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values, unmapped neighbours at both ends
        for (int a = 8'h90; a <= 8'h9a; a++)
            rc(8'(a), (a == 8'h99) ? 8'h03 : 8'h00);
        chkIrq(1'b0);
        rl = 8'($random(seed)) & 8'h7f;
        rh = 8'($random(seed)) & 8'h7f;
        cv = 8'($random(seed));
        // Each read right behind its write, so the read-back check fires
        wr(A_RLL, rl);
        rc(A_RLL, rl);
        wr(A_RLH, rh);
        rc(A_RLH, rh);
        wr(A_CTRL, 8'h12);
        rc(A_CTRL, 8'h00);
        // Wide mode holds while stopped
        wr(A_CLK, 8'h01);
        wr(A_CL, cv);
        wr(A_CH, ~cv);
        repeat (20) @(posedge ref_clk);
        rc(A_CL, cv);
        rc(A_CH, ~cv);
        // Wide wrap from ffff reloads both bytes
        wr(A_IEN, 8'h01);
        wr(A_CH, 8'hff);
        wr(A_CL, 8'hfe);
        wr(A_CTRL, 8'h04);
        repeat (6) @(posedge ref_clk);
        rc(A_CTRL, 8'hc4);
        rc(A_CH, rh);
        rd(A_CL);
        chkIn(rl, rl + 8'h20);
        chkIrq(1'b1);
        rc(A_STAT, 8'h03);
        repeat (30) @(posedge ref_clk);
        rc(A_CTRL, 8'hc4);
        wr(A_CTRL, 8'h00);
        wr(A_STAT, 8'h03);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        // Low byte wrap alone in wide mode
        wr(A_CH, 8'h10);
        wr(A_CL, 8'hfd);
        wr(A_CTRL, 8'h04);
        repeat (8) @(posedge ref_clk);
        rc(A_CTRL, 8'h44);
        rc(A_CH, 8'h11);
        chkIrq(1'b0);
        wr(A_CTRL, 8'h64);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b1);
        // Pending status alone must not raise the request
        wr(A_IEN, 8'h00);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        wr(A_IEN, 8'h01);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b1);
        wr(A_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        wr(A_MASK, 8'h03);
        wr(A_CTRL, 8'h00);
        wr(A_STAT, 8'h03);
        // Split mode: low runs alone, high waits for run
        wr(A_CLK, 8'h03);
        wr(A_CL, 8'hfc);
        wr(A_CH, 8'hff);
        wr(A_CTRL, 8'h08);
        repeat (10) @(posedge ref_clk);
        rc(A_CH, 8'hff);
        rc(A_CTRL, 8'h48);
        rd(A_CL);
        chkIn(rl, rl + 8'h20);
        chkIrq(1'b0);
        wr(A_CTRL, 8'h6c);
        repeat (4) @(posedge ref_clk);
        rd(A_CH);
        chkIn(rh, rh + 8'h10);
        rc(A_CTRL, 8'hec);
        chkIrq(1'b1);
        wr(A_CTRL, 8'h00);
        wr(A_STAT, 8'h03);
        // Per-byte select: high on system clock, low on divide by 12
        wr(A_CLK, 8'h02);
        wr(A_CL, 8'h00);
        wr(A_CH, 8'h00);
        wr(A_CTRL, 8'h0c);
        repeat (24) @(posedge ref_clk);
        wr(A_CTRL, 8'h08);
        rd(A_CH);
        chkIn(8'h18, 8'h1c);
        rd(A_CL);
        chkIn(8'h01, 8'h03);
        // Wide mode on divide by 12
        wr(A_CTRL, 8'h00);
        wr(A_CLK, 8'h00);
        wr(A_CL, 8'h00);
        wr(A_CTRL, 8'h04);
        repeat (120) @(posedge ref_clk);
        wr(A_CTRL, 8'h00);
        rd(A_CL);
        chkIn(8'h09, 8'h0c);
        // Wide mode on synchronized external clock by 8
        wr(A_CL, 8'h00);
        extOn <= 1'b1;
        wr(A_CTRL, 8'h05);
        repeat (160) @(posedge ref_clk);
        wr(A_CTRL, 8'h01);
        rd(A_CL);
        chkIn(8'h08, 8'h0b);
        summarize();
    end
endmodule
